// [hw/ddc_params.svh]
`ifndef DDC_PARAMS_SVH
`define DDC_PARAMS_SVH

// Sample stream and buffering
`define DDC_DATA_W 32
`define DDC_FIFO_DEPTH 8
`define DDC_IN_W 16
`define DDC_REAL_W 12
`define DDC_OUT_W 15

// Link word layout
`define DDC_DATA_I_LSB 17
`define DDC_DATA_Q_LSB 2
`define DDC_DATA_REAL_LSB 2
`define DDC_DATA_CPLX_BIT 0

// Half-band cascade
`define DDC_HB_STAGES 5
`define DDC_HB_TAPS 6
`define DDC_STAGE_W 18
`define DDC_ACC_W 24
`define DDC_HB_C_OUTER (-1)
`define DDC_HB_C_INNER 9
`define DDC_HB_C_CENTER 16
`define DDC_HB_SHIFT 5

// Oscillator
`define DDC_FREQ_W 32
`define DDC_PHASE_W 16

// Host sequencing, in ref_clk cycles
`define DDC_STEP_CYCLES 4
`define DDC_SYSREF_PERIOD 64
`define DDC_ARM_DELAY 4
`define DDC_PULSE_CYCLES 2

`endif

// [hw/ddc_pkg.sv]
package ddc_pkg;
    typedef enum logic [2:0] {
        DDC_BYPASS,
        DDC_DEC4,
        DDC_DEC8,
        DDC_DEC16,
        DDC_DEC32
    } ddc_dec_mode_t;

    typedef enum logic [1:0] {
        DDC_BY_LINK,
        DDC_BY_SYSREF_DC,
        DDC_BY_SYSREF_AC
    } ddc_sync_method_t;
endpackage

// [hw/ddc_link_if.sv]
`timescale 1ns/1ns
`include "ddc_params.svh"
interface ddc_link_if;
    logic serialLinkEnable;
    logic oscSyncOnLinkInit;
    logic oscSyncArmSysref; // Strobe on the last SPI data bit of the arming write
    logic linkEnc64;
    logic syncN;
    logic sysref;
    logic [`DDC_FREQ_W-1:0] freqWordChanA;
    logic [`DDC_FREQ_W-1:0] freqWordChanB;
    logic [`DDC_PHASE_W-1:0] phaseWordChanA;
    logic [`DDC_PHASE_W-1:0] phaseWordChanB;
    ddc_pkg::ddc_dec_mode_t decMode;
    logic dataValid;
    logic dataReady;
    logic [`DDC_DATA_W-1:0] data;

    modport dev (
        input serialLinkEnable, oscSyncOnLinkInit, oscSyncArmSysref, linkEnc64, syncN, sysref,
        input freqWordChanA, freqWordChanB, phaseWordChanA, phaseWordChanB, decMode, dataReady,
        output dataValid, data
    );
    modport host (
        output serialLinkEnable, oscSyncOnLinkInit, oscSyncArmSysref, linkEnc64, syncN, sysref,
        output freqWordChanA, freqWordChanB, phaseWordChanA, phaseWordChanB, decMode, dataReady,
        input dataValid, data
    );
endinterface

// [hw/ddc_fifo.sv]
`timescale 1ns/1ns
module ddc_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid_r,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData_r
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_r;
    logic [AW-1:0] rdPtr_r;
    logic [CW-1:0] count_r;
    logic push;
    logic pop;

    function automatic logic [AW-1:0] ptrInc(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction

    // Output register refills whenever it is empty or being taken
    assign inReady = count_r != CW'(DEPTH);
    assign push = inValid && inReady;
    assign pop = (count_r != '0) && (!outValid_r || outReady);

    // Pointers and fill level
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) wrPtr_r <= ptrInc(wrPtr_r);
            if (pop) rdPtr_r <= ptrInc(rdPtr_r);
            count_r <= count_r + CW'(push) - CW'(pop);
        end
    end

    // Storage, no reset needed on data
    always_ff @(posedge ref_clk) begin
        if (push) mem[wrPtr_r] <= inData;
        if (pop) outData_r <= mem[rdPtr_r];
    end

    // Head word valid flag
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            outValid_r <= 1'b0;
        end else if (pop) begin
            outValid_r <= 1'b1;
        end else if (outReady) begin
            outValid_r <= 1'b0;
        end
    end
endmodule

// [hw/ddc_device.sv]
// What this block does
// - Sync enable selects SYNC as oscillator trigger
// - Host disables link, programs words, toggles SYNC
// - SYNC low starts CGS or arms trigger
// - SYNC release high synchronizes all oscillators
// - Host holds SYSREF low before a DC arm
// - One SYSREF pulse synchronizes armed oscillators
// - Host times arm write between SYSREF edges
// - Armed device syncs on next SYSREF rise
// - Long SYSREF period recommended for AC arming
// - Bypass passes real 12-bit samples undecimated
// - Decimating modes output complex 15-bit data
// - Each decimation filter is linear-phase FIR
// - Output rate is device clock over D
// - Stage cascade order per decimation factor
// - Symmetric taps share multipliers around center
// - Each stage halves rate, scales by shift
// - Sync at link init or SYSREF per bits
// - Host resyncs after any frequency word change
`timescale 1ns/1ns
`include "ddc_params.svh"
module ddc_device (
    input wire logic ref_clk,
    input wire logic reset,
    ddc_link_if.dev link,
    input wire logic sampleValid,
    input wire logic [`DDC_REAL_W-1:0] realSample,
    input wire logic signed [`DDC_IN_W-1:0] iSample,
    input wire logic signed [`DDC_IN_W-1:0] qSample,
    output logic sampleReady_r,
    output logic cgsActive_r,
    output logic syncArmed_r,
    output logic syncEvent_r,
    output logic [`DDC_FREQ_W-1:0] ncoAccA_r,
    output logic [`DDC_FREQ_W-1:0] ncoAccB_r
);
    localparam int NS = `DDC_HB_STAGES;
    localparam int SW = `DDC_STAGE_W;

    typedef enum logic [1:0] {DS_IDLE, DS_WAIT_LOW, DS_CGS, DS_DONE} ddc_dev_state_t;

    ddc_dev_state_t state_r;
    logic [2:0] pinMeta_r;
    logic [2:0] pinSync_r;
    logic [2:0] pinPrev_r;
    logic syncRise;
    logic sysrefRise;
    logic armPulse;
    logic linkFire;
    logic sysrefFire;
    logic fire;

    // Symmetric half-band sum: mirrored taps are added before the multiply
    function automatic logic signed [SW-1:0] hbSum(
        input logic signed [SW-1:0] xo1,
        input logic signed [SW-1:0] xi1,
        input logic signed [SW-1:0] xc,
        input logic signed [SW-1:0] xi2,
        input logic signed [SW-1:0] xo2
    );
        logic signed [`DDC_ACC_W-1:0] acc;
        acc = `DDC_ACC_W'(`DDC_HB_C_OUTER * (`DDC_ACC_W'(xo1) + `DDC_ACC_W'(xo2)))
            + `DDC_ACC_W'(`DDC_HB_C_INNER * (`DDC_ACC_W'(xi1) + `DDC_ACC_W'(xi2)))
            + `DDC_ACC_W'(`DDC_HB_C_CENTER * `DDC_ACC_W'(xc));
        return SW'(acc >>> `DDC_HB_SHIFT);
    endfunction

    // Index of the first active stage; stages run in order toward the last
    function automatic logic [2:0] firstStage(input ddc_pkg::ddc_dec_mode_t m);
        unique case (m)
            ddc_pkg::DDC_DEC4: return 3'h3;
            ddc_pkg::DDC_DEC8: return 3'h2;
            ddc_pkg::DDC_DEC16: return 3'h1;
            ddc_pkg::DDC_DEC32: return 3'h0;
            default: return 3'h5;
        endcase
    endfunction

    // SYNC, SYSREF and the arm strobe are pins: two flops, then a history flop
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pinMeta_r <= 3'h1;
            pinSync_r <= 3'h1;
            pinPrev_r <= 3'h1;
        end else begin
            pinMeta_r <= {link.oscSyncArmSysref, link.sysref, link.syncN};
            pinSync_r <= pinMeta_r;
            pinPrev_r <= pinSync_r;
        end
    end

    assign syncRise = pinSync_r[0] && !pinPrev_r[0];
    assign sysrefRise = pinSync_r[1] && !pinPrev_r[1];
    assign armPulse = pinSync_r[2] && !pinPrev_r[2];
    assign linkFire = (state_r == DS_CGS) && syncRise;
    assign sysrefFire = syncArmed_r && sysrefRise;
    assign fire = linkFire || sysrefFire;

    // Link-init sequencing; dropping the link enable restarts it
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_r <= DS_IDLE;
            cgsActive_r <= 1'b0;
        end else if (!link.serialLinkEnable || !link.oscSyncOnLinkInit) begin
            state_r <= DS_IDLE;
            cgsActive_r <= 1'b0;
        end else begin
            unique case (state_r)
                DS_IDLE: if (pinSync_r[0]) state_r <= DS_WAIT_LOW;
                DS_WAIT_LOW: if (!pinSync_r[0]) begin
                    state_r <= DS_CGS;
                    cgsActive_r <= !link.linkEnc64;
                end
                DS_CGS: if (syncRise) begin
                    state_r <= DS_DONE;
                    cgsActive_r <= 1'b0;
                end
                DS_DONE: state_r <= DS_DONE;
            endcase
        end
    end

    // One-shot SYSREF arm; a new arm in the consuming cycle survives
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            syncArmed_r <= 1'b0;
        end else if (armPulse) begin
            syncArmed_r <= 1'b1;
        end else if (sysrefFire) begin
            syncArmed_r <= 1'b0;
        end
    end

    // Phase accumulators; the offset is left-justified into the word
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ncoAccA_r <= '0;
            ncoAccB_r <= '0;
            syncEvent_r <= 1'b0;
        end else begin
            syncEvent_r <= fire;
            if (fire) begin
                ncoAccA_r <= {link.phaseWordChanA, 16'h0000};
                ncoAccB_r <= {link.phaseWordChanB, 16'h0000};
            end else begin
                ncoAccA_r <= ncoAccA_r + link.freqWordChanA;
                ncoAccB_r <= ncoAccB_r + link.freqWordChanB;
            end
        end
    end

    // Input skid: a sample taken while the buffer is full waits here
    logic fifoInReady;
    logic advance;
    logic holdValid_r;
    logic holdValidNxt;
    logic srcValid;
    logic [`DDC_REAL_W-1:0] holdReal_r;
    logic signed [`DDC_IN_W-1:0] holdI_r;
    logic signed [`DDC_IN_W-1:0] holdQ_r;
    logic [`DDC_REAL_W-1:0] srcReal;
    logic signed [`DDC_IN_W-1:0] srcI;
    logic signed [`DDC_IN_W-1:0] srcQ;

    assign advance = fifoInReady; // Whole pipeline stalls on a full buffer
    assign srcValid = holdValid_r || (sampleValid && sampleReady_r);
    assign srcReal = holdValid_r ? holdReal_r : realSample;
    assign srcI = holdValid_r ? holdI_r : iSample;
    assign srcQ = holdValid_r ? holdQ_r : qSample;
    assign holdValidNxt = srcValid && !advance;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            holdValid_r <= 1'b0;
            sampleReady_r <= 1'b1;
        end else begin
            holdValid_r <= holdValidNxt;
            sampleReady_r <= !holdValidNxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!holdValid_r) begin
            holdReal_r <= realSample;
            holdI_r <= iSample;
            holdQ_r <= qSample;
        end
    end

    // Half-band cascade, each stage keeps every second output
    logic signed [SW-1:0] tapI_r [NS][`DDC_HB_TAPS];
    logic signed [SW-1:0] tapQ_r [NS][`DDC_HB_TAPS];
    logic signed [SW-1:0] stgI_r [NS];
    logic signed [SW-1:0] stgQ_r [NS];
    logic stgV_r [NS];
    logic phase_r [NS];
    logic inV [NS];
    logic signed [SW-1:0] inI [NS];
    logic signed [SW-1:0] inQ [NS];
    logic [2:0] first;

    always_comb begin
        first = firstStage(link.decMode);
        inV[0] = srcValid && (first == 3'h0);
        inI[0] = SW'(srcI);
        inQ[0] = SW'(srcQ);
        for (int k = 1; k < NS; k++) begin
            if (3'(k) == first) begin
                inV[k] = srcValid;
                inI[k] = SW'(srcI);
                inQ[k] = SW'(srcQ);
            end else begin
                inV[k] = stgV_r[k-1] && (3'(k) > first);
                inI[k] = stgI_r[k-1];
                inQ[k] = stgQ_r[k-1];
            end
        end
    end

    // Stage control: valid and decimation phase
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            for (int k = 0; k < NS; k++) begin
                stgV_r[k] <= 1'b0;
                phase_r[k] <= 1'b0;
            end
        end else if (advance) begin
            for (int k = 0; k < NS; k++) begin
                stgV_r[k] <= inV[k] && phase_r[k];
                if (inV[k]) phase_r[k] <= !phase_r[k];
            end
        end
    end

    // Stage data: delay line and filtered output
    always_ff @(posedge ref_clk) begin
        if (advance) begin
            for (int k = 0; k < NS; k++) begin
                if (inV[k]) begin
                    tapI_r[k][0] <= inI[k];
                    tapQ_r[k][0] <= inQ[k];
                    for (int t = 1; t < `DDC_HB_TAPS; t++) begin
                        tapI_r[k][t] <= tapI_r[k][t-1];
                        tapQ_r[k][t] <= tapQ_r[k][t-1];
                    end
                    stgI_r[k] <= hbSum(inI[k], tapI_r[k][1], tapI_r[k][2], tapI_r[k][3], tapI_r[k][5]);
                    stgQ_r[k] <= hbSum(inQ[k], tapQ_r[k][1], tapQ_r[k][2], tapQ_r[k][3], tapQ_r[k][5]);
                end
            end
        end
    end

    // Final word into the buffer
    logic finalV_r;
    logic [`DDC_DATA_W-1:0] finalData_r;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            finalV_r <= 1'b0;
            finalData_r <= '0;
        end else if (advance) begin
            if (link.decMode == ddc_pkg::DDC_BYPASS) begin
                finalV_r <= srcValid;
                finalData_r <= '0;
                finalData_r[`DDC_DATA_REAL_LSB +: `DDC_REAL_W] <= srcReal;
            end else begin
                finalV_r <= stgV_r[NS-1];
                finalData_r <= '0;
                finalData_r[`DDC_DATA_I_LSB +: `DDC_OUT_W] <= stgI_r[NS-1][`DDC_OUT_W:1];
                finalData_r[`DDC_DATA_Q_LSB +: `DDC_OUT_W] <= stgQ_r[NS-1][`DDC_OUT_W:1];
                finalData_r[`DDC_DATA_CPLX_BIT] <= 1'b1;
            end
        end
    end

    ddc_fifo #(
        .WIDTH(`DDC_DATA_W),
        .DEPTH(`DDC_FIFO_DEPTH)
    ) outFifo (
        .ref_clk(ref_clk),
        .reset(reset),
        .inValid(finalV_r),
        .inReady(fifoInReady),
        .inData(finalData_r),
        .outValid_r(link.dataValid),
        .outReady(link.dataReady),
        .outData_r(link.data)
    );
endmodule

// [hw/ddc_host.sv]
`timescale 1ns/1ns
`include "ddc_params.svh"
module ddc_host (
    input wire logic ref_clk,
    input wire logic reset,
    ddc_link_if.host link,
    input wire logic cmdStart,
    input wire ddc_pkg::ddc_sync_method_t cmdMethod,
    input wire logic cgsDone,
    input wire logic [`DDC_FREQ_W-1:0] cfgFreqA,
    input wire logic [`DDC_FREQ_W-1:0] cfgFreqB,
    input wire logic [`DDC_PHASE_W-1:0] cfgPhaseA,
    input wire logic [`DDC_PHASE_W-1:0] cfgPhaseB,
    input wire ddc_pkg::ddc_dec_mode_t cfgDecMode,
    input wire logic cfgEnc64,
    input wire logic outReady,
    output logic busy_r,
    output logic outValid_r,
    output logic [`DDC_DATA_W-1:0] outData_r
);
    typedef enum logic [3:0] {
        H_IDLE, H_LINK_OFF, H_PROG, H_SYNC_HI, H_LINK_ON, H_SYNC_LO, H_WAIT_CGS, H_ARM, H_PULSE
    } ddc_host_state_t;

    localparam logic [7:0] STEP = 8'(`DDC_STEP_CYCLES);
    localparam logic [7:0] PERIOD = 8'(`DDC_SYSREF_PERIOD);

    ddc_host_state_t state_r;
    ddc_pkg::ddc_sync_method_t method_r;
    logic [7:0] wait_r;
    logic [7:0] period_r;
    logic acRun_r;

    // Free-running SYSREF for the AC method, high in the first half period
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            period_r <= '0;
        end else begin
            period_r <= (period_r == PERIOD - 8'h01) ? 8'h00 : period_r + 8'h01;
        end
    end

    // Sync sequencer; every step but H_WAIT_CGS waits a few cycles for pin synchronisers
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_r <= H_IDLE;
            method_r <= ddc_pkg::DDC_BY_LINK;
            wait_r <= '0;
            acRun_r <= 1'b0;
            busy_r <= 1'b0;
            link.serialLinkEnable <= 1'b0;
            link.oscSyncOnLinkInit <= 1'b0;
            link.oscSyncArmSysref <= 1'b0;
            link.syncN <= 1'b1;
            link.sysref <= 1'b0;
            link.freqWordChanA <= '0;
            link.freqWordChanB <= '0;
            link.phaseWordChanA <= '0;
            link.phaseWordChanB <= '0;
            link.decMode <= ddc_pkg::DDC_BYPASS;
            link.linkEnc64 <= 1'b0;
        end else begin
            link.oscSyncArmSysref <= 1'b0;
            link.sysref <= acRun_r && (period_r < (PERIOD >> 1));
            if (wait_r != 8'h00) begin
                wait_r <= wait_r - 8'h01;
            end else begin
                unique case (state_r)
                    H_IDLE: if (cmdStart) begin
                        method_r <= cmdMethod;
                        busy_r <= 1'b1;
                        link.decMode <= cfgDecMode;
                        link.linkEnc64 <= cfgEnc64;
                        acRun_r <= cmdMethod == ddc_pkg::DDC_BY_SYSREF_AC;
                        link.oscSyncOnLinkInit <= cmdMethod == ddc_pkg::DDC_BY_LINK;
                        state_r <= (cmdMethod == ddc_pkg::DDC_BY_LINK) ? H_LINK_OFF : H_LINK_ON;
                        wait_r <= STEP;
                    end
                    H_LINK_OFF: begin
                        link.serialLinkEnable <= 1'b0;
                        state_r <= H_PROG;
                        wait_r <= STEP;
                    end
                    H_PROG: begin
                        link.freqWordChanA <= cfgFreqA;
                        link.freqWordChanB <= cfgFreqB;
                        link.phaseWordChanA <= cfgPhaseA;
                        link.phaseWordChanB <= cfgPhaseB;
                        state_r <= (method_r == ddc_pkg::DDC_BY_LINK) ? H_SYNC_HI : H_ARM;
                        wait_r <= STEP;
                    end
                    H_SYNC_HI: begin
                        link.syncN <= 1'b1;
                        state_r <= H_LINK_ON;
                        wait_r <= STEP;
                    end
                    H_LINK_ON: begin
                        link.serialLinkEnable <= 1'b1;
                        state_r <= (method_r == ddc_pkg::DDC_BY_LINK) ? H_SYNC_LO : H_PROG;
                        wait_r <= STEP;
                    end
                    H_SYNC_LO: begin
                        link.syncN <= 1'b0;
                        state_r <= H_WAIT_CGS;
                        wait_r <= STEP;
                    end
                    H_WAIT_CGS: if (cgsDone) begin
                        link.syncN <= 1'b1;
                        state_r <= H_IDLE;
                        busy_r <= 1'b0;
                    end
                    H_ARM: if (method_r != ddc_pkg::DDC_BY_SYSREF_AC ||
                               period_r == 8'(`DDC_ARM_DELAY)) begin
                        link.oscSyncArmSysref <= 1'b1;
                        state_r <= (method_r == ddc_pkg::DDC_BY_SYSREF_AC) ? H_IDLE : H_PULSE;
                        busy_r <= method_r != ddc_pkg::DDC_BY_SYSREF_AC;
                        wait_r <= STEP;
                    end
                    H_PULSE: begin
                        link.sysref <= 1'b1;
                        state_r <= H_IDLE;
                        busy_r <= 1'b0;
                        wait_r <= 8'(`DDC_PULSE_CYCLES);
                    end
                    default: state_r <= H_IDLE;
                endcase
            end
            if (state_r == H_IDLE && wait_r != 8'h00 && !acRun_r) begin
                link.sysref <= 1'b1; // Stretch the single DC pulse
            end
        end
    end

    // One-word receive register toward the user
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            outValid_r <= 1'b0;
            outData_r <= '0;
            link.dataReady <= 1'b1;
        end else if (link.dataValid && link.dataReady) begin
            outValid_r <= 1'b1;
            outData_r <= link.data;
            link.dataReady <= 1'b0;
        end else if (outValid_r && outReady) begin
            outValid_r <= 1'b0;
            link.dataReady <= 1'b1;
        end
    end
endmodule

// [sim/ddc_link_props.sv]
`timescale 1ns/1ns
`include "ddc_params.svh"
module ddc_link_props (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic serialLinkEnable,
    input wire logic oscSyncOnLinkInit,
    input wire logic oscSyncArmSysref,
    input wire logic syncN,
    input wire ddc_pkg::ddc_dec_mode_t decMode,
    input wire logic dataValid,
    input wire logic dataReady,
    input wire logic [`DDC_DATA_W-1:0] data
);
    // One clock domain, so one default for every check
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    word_held_a: assert property (dataValid && !dataReady |=> dataValid && $stable(data))
        else $error("link word changed before taken");
    half_rate_a: assert property (dataValid && dataReady |=> !(dataValid && dataReady))
        else $error("two link words in adjacent cycles");
    cplx_flag_a: assert property (dataValid && decMode != ddc_pkg::DDC_BYPASS |-> data[0])
        else $error("decimated word lacks complex flag");
    real_fmt_a: assert property (dataValid && decMode == ddc_pkg::DDC_BYPASS |->
        data[31:14] == 18'h0 && data[1:0] == 2'h0) else $error("bypass word has stray bits");
    arm_pulse_a: assert property ($rose(oscSyncArmSysref) |=> !oscSyncArmSysref)
        else $error("arm strobe longer than one cycle");
    arm_link_a: assert property (oscSyncArmSysref |-> serialLinkEnable)
        else $error("sysref arm before link enabled");
    sync_order_a: assert property ($rose(serialLinkEnable) && oscSyncOnLinkInit |-> syncN)
        else $error("link enabled while sync low");
    sync_low_a: assert property ($fell(syncN) |-> serialLinkEnable && oscSyncOnLinkInit)
        else $error("sync asserted with link off");
endmodule

// [sim/tb_ddc_nco_sync_decimation.sv]
`timescale 1ns/1ns
`include "ddc_params.svh"
module tb_ddc_nco_sync_decimation;
    logic ref_clk = 0, reset = 1, cmdStart = 0, cgsDone = 0, outReady = 1, sampleValid = 0;
    ddc_pkg::ddc_sync_method_t cmdMethod = ddc_pkg::DDC_BY_LINK;
    ddc_pkg::ddc_dec_mode_t cfgDecMode = ddc_pkg::DDC_BYPASS;
    logic [15:0] cfgPhase = 16'h0;
    logic [11:0] realSample = 12'h0;
    logic sampleReady_r, cgsActive_r, syncArmed_r, syncEvent_r, busy_r, outValid_r;
    logic [31:0] ncoAccA_r, ncoAccB_r, outData_r;
    logic [31:0] got[$];
    int n_errors = 0, checked = 0, nEv = 0;
    ddc_link_if link();
    ddc_device ddc_device_i (.ref_clk(ref_clk), .reset(reset), .link(link), .sampleValid(sampleValid),
        .realSample(realSample), .iSample(16'sh0), .qSample(16'sh0), .sampleReady_r(sampleReady_r),
        .cgsActive_r(cgsActive_r), .syncArmed_r(syncArmed_r), .syncEvent_r(syncEvent_r),
        .ncoAccA_r(ncoAccA_r), .ncoAccB_r(ncoAccB_r));
    ddc_host ddc_host_i (.ref_clk(ref_clk), .reset(reset), .link(link), .cmdStart(cmdStart),
        .cmdMethod(cmdMethod), .cgsDone(cgsDone), .cfgFreqA(32'h0), .cfgFreqB(32'h0), .cfgPhaseA(cfgPhase),
        .cfgPhaseB(~cfgPhase), .cfgDecMode(cfgDecMode), .cfgEnc64(1'b0), .outReady(outReady),
        .busy_r(busy_r), .outValid_r(outValid_r), .outData_r(outData_r));
    ddc_link_props ddc_link_props_i (.ref_clk(ref_clk), .reset(reset),
        .serialLinkEnable(link.serialLinkEnable), .oscSyncOnLinkInit(link.oscSyncOnLinkInit),
        .oscSyncArmSysref(link.oscSyncArmSysref), .syncN(link.syncN), .decMode(link.decMode),
        .dataValid(link.dataValid), .dataReady(link.dataReady), .data(link.data));
    // 50 MHz device clock
    always #10 ref_clk = ~ref_clk;
    // Collect words as the host hands them over, and count the device's sync pulses
    always @(posedge ref_clk) begin
        if (outValid_r === 1'b1 && outReady) got.push_back(outData_r);
        if (syncEvent_r === 1'b1) nEv++;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("errors %0d, comparisons %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Bounded wait; a hang counts as a mismatch rather than stalling the run
    task automatic waitFor(ref logic sig, input logic lvl);
        int w = 0;
        while (sig !== lvl && w < 3000) begin
            @(negedge ref_clk);
            w++;
        end
        chk({31'h0, sig}, {31'h0, lvl});
    endtask
    task automatic cmd(input ddc_pkg::ddc_sync_method_t m, input ddc_pkg::ddc_dec_mode_t d, input logic [15:0] ph);
        @(negedge ref_clk);
        cmdMethod = m;
        cfgDecMode = d;
        cfgPhase = ph;
        cmdStart = 1;
        nEv = 0;
        @(negedge ref_clk) cmdStart = 0;
        repeat (2) @(negedge ref_clk);
    endtask
    task automatic feed(input int n);
        int k = 0;
        while (k < n) begin
            @(negedge ref_clk);
            sampleValid = 1;
            realSample = 12'h800 + k[11:0];
            @(posedge ref_clk);
            if (sampleReady_r) k++;
        end
        @(negedge ref_clk) sampleValid = 0;
    endtask
    // Link-init sync: sync release reloads both accumulators once
    task automatic testLinkSync();
        cmd(ddc_pkg::DDC_BY_LINK, ddc_pkg::DDC_BYPASS, 16'h1234);
        waitFor(cgsActive_r, 1'b1);
        cgsDone = 1;
        waitFor(busy_r, 1'b0);
        cgsDone = 0;
        // Release passes two pin flops, then the reload and the event pulse come on the same edge
        repeat (8) @(negedge ref_clk);
        chk(ncoAccA_r, 32'h12340000);
        chk(ncoAccB_r, 32'hedcb0000);
        chk(nEv, 1);
    endtask
    // Sysref sync, DC pulse or free-running AC: one reload, arm then consumed
    task automatic testSysref(input ddc_pkg::ddc_sync_method_t m, input logic [15:0] ph);
        cmd(m, ddc_pkg::DDC_BYPASS, ph);
        waitFor(busy_r, 1'b0);
        repeat (300) @(negedge ref_clk);
        chk(ncoAccA_r, {ph, 16'h0});
        chk(nEv, 1);
        chk({31'h0, syncArmed_r}, 32'h0);
    endtask
    // Bypass with far side stalled: FIFO fills, refuses, then drains in order
    task automatic testBypass();
        got = {};
        outReady = 0;
        fork
            feed(16);
            begin
                repeat (80) @(negedge ref_clk);
                chk({31'h0, sampleReady_r}, 32'h0);
                outReady = 1;
            end
        join
        repeat (40) @(negedge ref_clk);
        chk(got.size(), 16);
        foreach (got[i]) chk(got[i], {18'h0, 12'h800 + i[11:0], 2'h0});
    endtask
    // Each decimating mode: 128 inputs give 128/D complex words
    task automatic testDecim();
        ddc_pkg::ddc_dec_mode_t d;
        for (int j = 0; j < 4; j++) begin
            d = ddc_pkg::ddc_dec_mode_t'(j + 1);
            cmd(ddc_pkg::DDC_BY_SYSREF_DC, d, 16'h0);
            waitFor(busy_r, 1'b0);
            got = {};
            feed(128);
            repeat (200) @(negedge ref_clk);
            chk(got.size(), 128 >> (j + 2));
            foreach (got[i]) chk(got[i], 32'h1);
        end
    endtask
    initial begin
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk) reset = 0;
        testLinkSync();
        testSysref(ddc_pkg::DDC_BY_SYSREF_DC, 16'h4321);
        testSysref(ddc_pkg::DDC_BY_SYSREF_AC, 16'h0f0f);
        testBypass();
        testDecim();
        results();
    end
    // Whole run needs well under 20000 cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        results();
    end
endmodule
